// *** hw/vbmpp_defs.svh ***
// Constants for the bus voltage monitor and power path block
`ifndef VBMPP_DEFS_SVH
`define VBMPP_DEFS_SVH
`define VBMPP_CLK_NS        4
`define VBMPP_MS_NS         1000000
`define VBMPP_PROF_STEP_MS  20
`define VBMPP_ZERO_STEP_MS  84
`define VBMPP_PROF_WIN_MS   280
`define VBMPP_ERR_HOLD_MS   30
`define VBMPP_BASE_PCT      5
`define VBMPP_FULL_PCT      100
`define VBMPP_PROF_WIN_RST  4'he
`define VBMPP_ZERO_RST      4'h2
`define VBMPP_SHIFT_RST     4'h5
`endif

// *** hw/vbmpp_pkg.sv ***
// Types for the bus voltage monitor and power path block
`default_nettype none
package vbmpp_pkg;
    typedef enum logic [1:0] {
        ATT_NONE = 2'b00,
        ATT_SRC  = 2'b01,
        ATT_DBG  = 2'b10,
        ATT_ACC  = 2'b11
    } vbmpp_attach_e;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_LIVE   = 2'b01,
        ST_REFUSE = 2'b10,
        ST_ERR    = 2'b11
    } vbmpp_state_e;
    typedef struct packed {
        logic [3:0] shiftHi;
        logic [3:0] shiftLo;
        logic [3:0] profWin;
        logic [3:0] zeroTime;
        logic       uvEn;
        logic       ovEn;
        logic       windowEn;
    } vbmpp_cfg_s;
endpackage
`default_nettype wire

// *** hw/vbmpp_power_path.sv ***
// Bus voltage window monitor, discharge control and power path enable
// How it works
// - Refuse attach when bus outside window
// - Leaving window after attach enters error recovery
// - Retarget nominal and blank checks after changes
// - Discharge during window on downward profile change
// - Base window is nominal plus/minus five percent
// - Extra outward shift up to fifteen percent
// - Separate shifts, nonvolatile default, writable while attached
// - Discharge on detach and error recovery entry
// - Discharge disable only from nonvolatile setting
// - Both discharge times loadable and software overridable
// - Enable low only in attached states, conditions met
// - Supply above undervolt, below overvolt when enabled
// - Bus in window, else just above undervolt
// - Supply check enables defaulted, software writable
// - After enable, monitor bus instead of supply
// - Error recovery removes terminations then goes unattached
// - Profile window set in 20 ms steps
// - External discharge output active low by default
`include "vbmpp_defs.svh"
`default_nettype none
module vbmpp_power_path
    import vbmpp_pkg::*;
#(
    parameter int MS_CYC = `VBMPP_MS_NS / `VBMPP_CLK_NS
) (
    input  wire logic          clk,              // 250 MHz clock
    input  wire logic          nrst,             // Async reset, active low
    input  wire vbmpp_attach_e attachState,      // Attach state from Type-C FSM
    input  wire logic          hwFault,          // Other hardware fault, pulse or level
    input  wire logic          profileChange,    // New profile taken, one-cycle pulse
    input  wire logic          profileDown,      // With profileChange: lower voltage
    input  wire logic [9:0]    targetVolt,       // Nominal bus voltage, 50 mV units
    input  wire logic [9:0]    busVoltSense,     // Digitised bus voltage, async
    input  wire logic          busUnderRaw,      // Bus below undervolt, async
    input  wire logic          supUnderRaw,      // Supply below undervolt, async
    input  wire logic          supOverRaw,       // Supply above overvolt, async
    input  wire vbmpp_cfg_s    nvmCfg,           // Nonvolatile defaults
    input  wire logic          nvmDischEn,       // Nonvolatile discharge enable
    input  wire logic          nvmExtActLow,     // External discharge active low
    input  wire logic          swCfgWr,          // Software config write pulse
    input  wire vbmpp_cfg_s    swCfg,            // Software config data
    output logic               srcPwrEnNOut,     // Power enable pin level, always 0
    output logic               srcPwrEnNOe,      // Power enable pulled low
    output logic               intDischarge,     // Internal discharge on
    output logic               extDischargeCtrl, // External discharge pin
    output logic               connRefused,      // Attach refused, level
    output logic               errRecovery,      // In error recovery, level
    output logic               ccTermRemove,     // Remove CC terminations
    output logic               toUnattached,     // Go unattached, one-cycle pulse
    output vbmpp_cfg_s         cfgOut            // Current configuration
);
    localparam int SW = 13;

    function automatic logic inWin(input logic [9:0] v, input logic [9:0] n,
                                   input logic [3:0] hi, input logic [3:0] lo);
        logic [17:0] vs;
        logic [17:0] hiLim;
        logic [17:0] loLim;
        vs    = 18'(v) * 18'(`VBMPP_FULL_PCT);
        hiLim = 18'(n) * (18'(`VBMPP_FULL_PCT + `VBMPP_BASE_PCT) + 18'(hi));
        loLim = 18'(n) * (18'(`VBMPP_FULL_PCT - `VBMPP_BASE_PCT) - 18'(lo));
        return (vs <= hiLim) && (vs >= loLim);
    endfunction

    // Three-stage capture; a new value counts once stages two and three agree
    logic [SW-1:0] s1_r, s2_r, s3_r, filt_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            filt_r <= '0;
        end else begin
            s1_r <= {busVoltSense, busUnderRaw, supUnderRaw, supOverRaw};
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                filt_r <= s3_r;
            end
        end
    end
    wire logic [9:0] busVolt  = filt_r[12:3];
    wire logic       busUnder = filt_r[2];
    wire logic       supUnder = filt_r[1];
    wire logic       supOver  = filt_r[0];

    vbmpp_state_e st_r, stNxt;
    vbmpp_cfg_s   cfg_r;
    logic         loaded_r, dischEn_r, extActLow_r, attPrev_r, downDisch_r;
    logic [17:0]  msCnt_r;
    logic [8:0]   blankMs_r;
    logic [10:0]  zeroMs_r;
    logic [5:0]   errMs_r;
    logic [9:0]   nominal_r;

    wire logic attachedSt = attachState != ATT_NONE;
    wire logic attachRise = attachedSt && !attPrev_r;
    wire logic detach     = !attachedSt && attPrev_r;
    wire logic msTick     = msCnt_r == 18'(MS_CYC - 1);
    wire logic blank      = blankMs_r != 9'h0;
    wire logic retarget   = attachRise || (profileChange && st_r == ST_LIVE);
    wire logic [9:0] nomUse = retarget ? targetVolt : nominal_r;
    wire logic winOk = inWin(busVolt, nomUse, cfg_r.shiftHi, cfg_r.shiftLo);
    wire logic busCheckOk = cfg_r.windowEn ? winOk : !busUnder;
    wire logic supplyOk = (!cfg_r.uvEn || !supUnder) && (!cfg_r.ovEn || !supOver);
    // Retarget cycle must be quiet too: the blank count only loads at its end
    wire logic suppress = blank || retarget;
    wire logic goErr = st_r == ST_LIVE && attachedSt
                       && (hwFault || (!suppress && !busCheckOk));
    // Supply is only consulted before the path is on; then bus sense takes over
    wire logic supGate = srcPwrEnNOe || supplyOk;
    wire logic enNxt = stNxt == ST_LIVE && attachedSt && (suppress || busCheckOk)
                       && supGate;
    wire logic dischAct = dischEn_r && (zeroMs_r != 11'h0 || downDisch_r);

    always_comb begin
        stNxt = st_r;
        unique case (st_r)
            ST_IDLE: begin
                if (attachRise) begin
                    stNxt = busCheckOk ? ST_LIVE : ST_REFUSE;
                end
            end
            ST_LIVE: begin
                if (detach) begin
                    stNxt = ST_IDLE;
                end else if (goErr) begin
                    stNxt = ST_ERR;
                end
            end
            ST_REFUSE: begin
                if (detach) begin
                    stNxt = ST_IDLE;
                end
            end
            ST_ERR: begin
                if (errMs_r == 6'h0) begin
                    stNxt = ST_IDLE;
                end
            end
        endcase
    end
    wire logic errEnter = stNxt == ST_ERR && st_r != ST_ERR;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loaded_r    <= 1'b0;
            cfg_r       <= '{`VBMPP_SHIFT_RST, `VBMPP_SHIFT_RST, `VBMPP_PROF_WIN_RST,
                             `VBMPP_ZERO_RST, 1'b1, 1'b1, 1'b1};
            dischEn_r   <= 1'b1;
            extActLow_r <= 1'b1;
        end else if (!loaded_r) begin
            loaded_r    <= 1'b1;
            cfg_r       <= nvmCfg;
            dischEn_r   <= nvmDischEn;
            extActLow_r <= nvmExtActLow;
        end else if (swCfgWr) begin
            cfg_r.profWin  <= swCfg.profWin;
            cfg_r.zeroTime <= swCfg.zeroTime;
            cfg_r.uvEn     <= swCfg.uvEn;
            cfg_r.ovEn     <= swCfg.ovEn;
            cfg_r.windowEn <= swCfg.windowEn;
            if (attachedSt) begin
                cfg_r.shiftHi <= swCfg.shiftHi;
                cfg_r.shiftLo <= swCfg.shiftLo;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r      <= ST_IDLE;
            attPrev_r <= 1'b0;
            msCnt_r   <= '0;
            nominal_r <= '0;
        end else begin
            st_r      <= stNxt;
            attPrev_r <= attachedSt;
            msCnt_r   <= msTick ? 18'h0 : msCnt_r + 18'h1;
            nominal_r <= nomUse;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blankMs_r   <= '0;
            downDisch_r <= 1'b0;
            zeroMs_r    <= '0;
            errMs_r     <= '0;
        end else begin
            if (retarget) begin
                blankMs_r <= 9'(cfg_r.profWin * `VBMPP_PROF_STEP_MS);
            end else if (stNxt != ST_LIVE) begin
                blankMs_r <= 9'h0;
            end else if (msTick && blank) begin
                blankMs_r <= blankMs_r - 9'h1;
            end
            if (profileChange && profileDown && st_r == ST_LIVE) begin
                downDisch_r <= 1'b1;
            end else if (!blank) begin
                downDisch_r <= 1'b0;
            end
            if (detach || errEnter) begin
                zeroMs_r <= 11'(cfg_r.zeroTime * `VBMPP_ZERO_STEP_MS);
            end else if (msTick && zeroMs_r != 11'h0) begin
                zeroMs_r <= zeroMs_r - 11'h1;
            end
            if (errEnter) begin
                errMs_r <= 6'(`VBMPP_ERR_HOLD_MS);
            end else if (msTick && errMs_r != 6'h0) begin
                errMs_r <= errMs_r - 6'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            srcPwrEnNOut     <= 1'b0;
            srcPwrEnNOe      <= 1'b0;
            intDischarge     <= 1'b0;
            extDischargeCtrl <= 1'b1;
            connRefused      <= 1'b0;
            errRecovery      <= 1'b0;
            ccTermRemove     <= 1'b0;
            toUnattached     <= 1'b0;
            cfgOut           <= '0;
        end else begin
            srcPwrEnNOut     <= 1'b0;
            srcPwrEnNOe      <= enNxt;
            intDischarge     <= dischAct;
            extDischargeCtrl <= extActLow_r ? !dischAct : dischAct;
            connRefused      <= stNxt == ST_REFUSE;
            errRecovery      <= stNxt == ST_ERR;
            ccTermRemove     <= stNxt == ST_ERR;
            toUnattached     <= st_r == ST_ERR && stNxt == ST_IDLE;
            cfgOut           <= cfg_r;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence seqErrHeld;
        (st_r == ST_ERR && ccTermRemove && !srcPwrEnNOe);
    endsequence

    AST_REFUSE_OFF: assert property (connRefused |-> !srcPwrEnNOe)
        else $error("Power path on after refused attach");
    AST_LEAVE_ERR: assert property (goErr && !detach |=> seqErrHeld)
        else $error("Window loss did not enter error recovery");
    AST_RETARGET_QUIET: assert property (profileChange && st_r == ST_LIVE && attachedSt
        && !hwFault |=> !errRecovery)
        else $error("Window checked during profile change");
    AST_BLANK_LOAD: assert property (retarget && loaded_r |=>
        blankMs_r == 9'($past(cfg_r.profWin) * `VBMPP_PROF_STEP_MS))
        else $error("Blanking window not loaded");
    AST_DOWN_DISCH: assert property (profileChange && profileDown && st_r == ST_LIVE
        && dischEn_r |=> ##1 intDischarge)
        else $error("No discharge on downward change");
    AST_DETACH_DISCH: assert property ((detach || errEnter) && dischEn_r
        && cfg_r.zeroTime != 4'h0 |=> ##1 intDischarge)
        else $error("No discharge on detach or error");
    AST_NO_SW_DISCH_OFF: assert property (loaded_r && $past(loaded_r)
        |-> $stable(dischEn_r))
        else $error("Discharge enable changed after load");
    AST_SHIFT_LOCK: assert property (loaded_r && swCfgWr && !attachedSt
        |=> $stable(cfg_r.shiftHi) && $stable(cfg_r.shiftLo))
        else $error("Shift written while detached");
    AST_EN_STATE: assert property (srcPwrEnNOe |-> $past(stNxt) == ST_LIVE
        && $past(attachedSt))
        else $error("Power path on outside attached state");
    AST_SUPPLY_GATE: assert property (!srcPwrEnNOe && !supplyOk |=> !srcPwrEnNOe)
        else $error("Power path on with supply fault");
    AST_EXT_POL: assert property (loaded_r && extActLow_r |=>
        extDischargeCtrl == !$past(dischAct))
        else $error("External discharge polarity wrong");
endmodule
`default_nettype wire

// *** sim/vbmpp_switch_model.sv ***
// Power switch and bus model: bus follows the source level, and is sunk only while discharging with the switch off
`default_nettype none
module vbmpp_switch_model #(
    parameter int UNDER_LVL = 40 // Bus undervolt level, 50 mV units
) (
    input  wire logic       clk,      // Bench clock
    input  wire logic       pwrOn,    // Enable pin pulled low
    input  wire logic       dischOn,  // Any discharge path on
    input  wire logic [9:0] srcVolt,  // Level the stage regulates to
    output var  logic [9:0] busVolt,  // Level at the sense pin
    output logic            busUnder  // Bus below undervolt level
);
    timeunit 1ns;
    timeprecision 1ps;
    initial busVolt = 10'h000;
    // A live switch wins over the sink, so discharge only drains an idle bus
    always @(posedge clk) begin
        if (dischOn && !pwrOn)
            busVolt <= (busVolt > 10'h008) ? busVolt - 10'h008 : 10'h000;
        else
            busVolt <= srcVolt;
    end
    assign busUnder = busVolt < 10'(UNDER_LVL);
endmodule
`default_nettype wire

// *** sim/vbmpp_power_path_tb.sv ***
// Self-checking bench for the bus monitor and power path block
`default_nettype none
module vbmpp_power_path_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vbmpp_pkg::*;
    localparam int MS = 10; // Cycles per ms, shortened so counts stay small
    logic          clk = 1'b0;
    logic          nrst = 1'b0;
    logic          profileChange = 1'b0;
    logic          profileDown = 1'b0;
    logic          supUnderRaw = 1'b0;
    logic          supOverRaw = 1'b0;
    logic          nvmDischEn = 1'b1;
    logic          nvmExtActLow = 1'b1;
    logic          hwFault = 1'b0;
    logic          swCfgWr = 1'b0;
    logic [9:0]    targetVolt = 10'h064;
    logic [9:0]    srcVolt = 10'h064;
    logic [9:0]    busVoltSense;
    logic          busUnderRaw, srcPwrEnNOut, srcPwrEnNOe, intDischarge, extDischargeCtrl;
    logic          connRefused, errRecovery, ccTermRemove, toUnattached;
    vbmpp_attach_e attachState = ATT_NONE;
    vbmpp_cfg_s    nvmCfg = {4'h5, 4'h5, 4'h1, 4'h1, 1'b1, 1'b1, 1'b1};
    vbmpp_cfg_s    swCfg = '0;
    vbmpp_cfg_s    cfgOut;
    logic [9:0]    edgeV [4] = '{10'h06e, 10'h06f, 10'h05a, 10'h059};
    int            n_errors = 0;
    int            checks_done = 0;

    always #2 clk = ~clk;

    vbmpp_power_path #(.MS_CYC(MS)) i_dut (.clk(clk), .nrst(nrst),
        .attachState(attachState), .hwFault(hwFault), .profileChange(profileChange),
        .profileDown(profileDown), .targetVolt(targetVolt), .busVoltSense(busVoltSense),
        .busUnderRaw(busUnderRaw), .supUnderRaw(supUnderRaw), .supOverRaw(supOverRaw),
        .nvmCfg(nvmCfg), .nvmDischEn(nvmDischEn), .nvmExtActLow(nvmExtActLow),
        .swCfgWr(swCfgWr),
        .swCfg(swCfg), .srcPwrEnNOut(srcPwrEnNOut), .srcPwrEnNOe(srcPwrEnNOe),
        .intDischarge(intDischarge), .extDischargeCtrl(extDischargeCtrl),
        .connRefused(connRefused), .errRecovery(errRecovery), .ccTermRemove(ccTermRemove),
        .toUnattached(toUnattached), .cfgOut(cfgOut));

    vbmpp_switch_model i_sw (.clk(clk), .pwrOn(srcPwrEnNOe),
        .dischOn(intDischarge | (extDischargeCtrl ^ nvmExtActLow)), .srcVolt(srcVolt),
        .busVolt(busVoltSense), .busUnder(busUnderRaw));

    function automatic logic inWin(input int v, nom, hi, lo);
        return v * 100 <= nom * (105 + hi) && v * 100 >= nom * (95 - lo);
    endfunction

    task automatic check(input logic [31:0] got, exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic endTest(input string s);
        $display("test %s done", s);
    endtask

    // Bus settles through the sync filter before the attach edge
    task automatic attach(input vbmpp_attach_e a, input logic [9:0] nom, v);
        srcVolt = v;
        tick(8);
        targetVolt = nom;
        attachState = a;
        tick(8);
    endtask

    task automatic detach();
        attachState = ATT_NONE;
        tick(4);
        for (int k = 0; k < 1200 && intDischarge !== 1'b0; k++)
            tick(1);
        check(intDischarge, 1'b0, "discharge never ended");
        tick(4);
    endtask

    task automatic wrCfg(input vbmpp_cfg_s c);
        swCfg = c;
        swCfgWr = 1'b1;
        tick(1);
        swCfgWr = 1'b0;
        tick(8);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #240000;
        n_errors++;
        finish_test();
    end

    initial begin
        int tU;
        int nD;
        logic [9:0] nom;
        logic [9:0] v;
        void'($urandom(32'hf289));
        tick(2);
        check({srcPwrEnNOe, extDischargeCtrl}, 2'b01, "reset levels");
        tick(2);
        nrst = 1'b1;
        tick(3);
        check(cfgOut, nvmCfg, "defaults");
        check(srcPwrEnNOut, 1'b0, "pin level");
        endTest("reset");
        foreach (edgeV[i]) begin
            attach(ATT_SRC, 10'h064, edgeV[i]);
            check(srcPwrEnNOe, inWin(edgeV[i], 100, 5, 5), "edge on");
            check(connRefused, !inWin(edgeV[i], 100, 5, 5), "edge refuse");
            detach();
        end
        // First three cover each attached mode with a surely good bus
        for (int i = 0; i < 6; i++) begin
            nom = 10'(60 + $urandom % 300);
            v = (i < 3) ? nom : 10'(nom * (80 + $urandom % 45) / 100);
            attach(vbmpp_attach_e'(1 + i % 3), nom, v);
            check(srcPwrEnNOe, inWin(v, nom, 5, 5), "random attach");
            detach();
        end
        endTest("window");
        supUnderRaw = 1'b1;
        attach(ATT_SRC, 10'h064, 10'h064);
        check(srcPwrEnNOe, 1'b0, "supply under");
        wrCfg({4'h5, 4'h5, 4'h1, 4'h1, 1'b0, 1'b1, 1'b1});
        check(srcPwrEnNOe, 1'b1, "uv check off");
        supUnderRaw = 1'b0;
        supOverRaw = 1'b1;
        tick(8);
        check(srcPwrEnNOe, 1'b1, "supply ignored");
        detach();
        supOverRaw = 1'b0;
        wrCfg({4'hf, 4'h5, 4'h1, 4'h1, 1'b1, 1'b1, 1'b0});
        check({cfgOut.shiftHi, cfgOut.windowEn}, 5'h0a, "detached write");
        attach(ATT_SRC, 10'h064, 10'h082);
        check(srcPwrEnNOe, 1'b1, "no window");
        detach();
        wrCfg(nvmCfg);
        endTest("supply");
        attach(ATT_SRC, 10'h064, 10'h064);
        srcVolt = 10'h082;
        tick(20);
        check(errRecovery, 1'b0, "attach blanking");
        srcVolt = 10'h064;
        tick(200);
        targetVolt = 10'h03c;
        srcVolt = 10'h03c;
        profileDown = 1'b1;
        profileChange = 1'b1;
        tick(1);
        profileChange = 1'b0;
        profileDown = 1'b0;
        tick(4);
        check({intDischarge, errRecovery}, 2'b10, "down step");
        tick(200);
        check(intDischarge, 1'b0, "window over");
        srcVolt = 10'h050;
        tick(10);
        check({errRecovery, ccTermRemove, srcPwrEnNOe}, 3'b110, "fault");
        tU = 0;
        nD = 0;
        for (int k = 1; k < 1200; k++) begin
            @(negedge clk);
            if (toUnattached)
                tU = k;
            if (intDischarge)
                nD++;
            if (k == 4)
                check({intDischarge, extDischargeCtrl}, 2'b10, "err disch");
        end
        // Entry was four cycles before the loop; ms counter phase adds up to one ms
        check(tU >= 29 * MS - 2 && tU <= 30 * MS - 3, 1'b1, "hold time");
        check(nD >= 84 * MS - 13 && nD <= 84 * MS - 4, 1'b1, "zero volt time");
        detach();
        endTest("fault");
        nrst = 1'b0;
        nvmDischEn = 1'b0;
        nvmExtActLow = 1'b0;
        tick(4);
        nrst = 1'b1;
        tick(3);
        check(extDischargeCtrl, 1'b0, "active high idle");
        attach(ATT_SRC, 10'h064, 10'h064);
        hwFault = 1'b1;
        tick(1);
        hwFault = 1'b0;
        tick(3);
        check(errRecovery, 1'b1, "hw fault");
        check({intDischarge, extDischargeCtrl}, 2'b00, "no err disch");
        attachState = ATT_NONE;
        tick(6);
        check(intDischarge, 1'b0, "discharge off");
        endTest("nvm discharge");
        finish_test();
    end
endmodule
`default_nettype wire
